// ==== include/sbr_pkg.sv ====
// Package of register map, field positions and prescale constants for the rate generator
package sbr_pkg;
    // Word byte addresses on the AHB-Lite slave
    localparam logic [7:0] SBR_S1_TXCTL_OFS = 8'h00;
    localparam logic [7:0] SBR_S1_RXCTL_OFS = 8'h04;
    localparam logic [7:0] SBR_S1_RATE_OFS = 8'h08;
    localparam logic [7:0] SBR_S1_DIVH_OFS = 8'h0C;
    localparam logic [7:0] SBR_S1_DIVL_OFS = 8'h10;
    localparam logic [7:0] SBR_S2_TXCTL_OFS = 8'h20;
    localparam logic [7:0] SBR_S2_RXCTL_OFS = 8'h24;
    localparam logic [7:0] SBR_S2_RATE_OFS = 8'h28;
    localparam logic [7:0] SBR_S2_DIVH_OFS = 8'h2C;
    localparam logic [7:0] SBR_S2_DIVL_OFS = 8'h30;
    localparam logic [7:0] SBR_PERIPHERAL_MODULE_DISABLE_0_OFS = 8'h40;
    localparam logic [7:0] SBR_STATUS_OFS = 8'h44;
    // Field positions
    localparam int SBR_SYNC_BIT = 4;
    localparam int SBR_HSPD_BIT = 2;
    localparam int SBR_WIDE_BIT = 3;
    localparam int SBR_RATE_UNIMP_BIT = 2;
    localparam int SBR_S2_MD_BIT = 2;
    localparam int SBR_S1_MD_BIT = 1;
    localparam int SBR_SPEN_BIT = 7;
    // Reset values
    localparam logic [7:0] SBR_REG_RST = 8'h00;
    // Prescale terminal counts (prescale minus one)
    localparam logic [5:0] SBR_PRE64_TC = 6'h3F;
    localparam logic [5:0] SBR_PRE16_TC = 6'h0F;
    localparam logic [5:0] SBR_PRE4_TC = 6'h03;
    // Majority sampling: vote over the last three samples
    localparam int SBR_NSAMPLES = 3;
endpackage

// ==== rtl/sbr_timer.sv ====
// Free-running rate timer with prescale for one serial instance
`timescale 1ns/100ps
module sbr_timer
    import sbr_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic run, // Port enabled and not disabled
    input wire logic restart, // Divisor write seen
    input wire logic [15:0] divisor, // Effective divisor n
    input wire logic [5:0] pre_tc, // Prescale minus one
    output logic timer_tick, // One cycle per n+1 clocks
    output logic bit_tick // One cycle per bit period
);
    logic [15:0] cnt_r;
    logic [5:0] pre_r;
    wire cnt_zero = (cnt_r == 16'h0000);
    wire pre_done = (pre_r >= pre_tc);

    // Count down from n, tick at zero, reload; prescale counts ticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            pre_r <= 6'h00;
            timer_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else if (ce) begin
            if (!run || restart) begin
                cnt_r <= divisor;
                pre_r <= 6'h00;
                timer_tick <= 1'b0;
                bit_tick <= 1'b0;
            end else begin
                cnt_r <= cnt_zero ? divisor : cnt_r - 16'h0001;
                timer_tick <= cnt_zero;
                bit_tick <= cnt_zero && pre_done;
                if (cnt_zero) begin
                    pre_r <= pre_done ? 6'h00 : pre_r + 6'h01;
                end
            end
        end
    end
endmodule

// ==== rtl/sbr_vote.sv ====
// Three-sample majority detector for a receive pin
`timescale 1ns/100ps
module sbr_vote
    import sbr_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic sample, // Take one sample now
    input wire logic pin, // Receive pin level
    output logic level // Majority decision
);
    logic [SBR_NSAMPLES-1:0] hist_r;

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    // Idle line is high, so history starts high to avoid a false start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_r <= 3'h7;
            level <= 1'b1;
        end else if (ce && sample) begin
            hist_r <= {hist_r[1:0], pin};
            level <= maj3({hist_r[1:0], pin});
        end
    end
endmodule

// ==== rtl/sbr_top.sv ====
// Dual rate generator with receive sampling and AHB-Lite register slave
//Function
// - Receive pin sampled once per timer tick, decided by majority vote of the last three samples.
// - Async, wide and high-speed clear: rate is clock over 64(n+1).
// - Async, exactly one of wide or high-speed set: clock over 16(n+1).
// - Sync mode: clock over 4(n+1), high-speed select ignored.
// - Divisor n is high byte above low byte.
// - Sync select at bit 4, high-speed select at bit 2 of transmit control.
// - Wide select at bit 3 of rate control; bit 2 reads zero.
// - Module disable: serial two at bit 2, serial one at bit 1.
// - Each serial instance owns its divisor pair and control registers.
// - Wide select clear: only low byte used, high byte ignored.
// - Any divisor write restarts the rate timer at once.
// - Divisor pair sets period of a free-running timer.
`timescale 1ns/100ps
module sbr_top
    import sbr_pkg::*;
(
    SYS_CLK, // 50 MHz system clock
    NRST, // Async reset, active low
    CE, // Clock enable, freezes all state when low
    HSEL, // Slave select
    HADDR, // Byte address
    HTRANS, // Transfer type
    HWRITE, // Write when high
    HSIZE, // Transfer size
    HWDATA, // Write data
    HREADY, // Bus ready in
    HRDATA, // Read data
    HREADYOUT, // Slave ready
    HRESP, // Response, always OKAY
    RX1_PIN, // Serial one receive pin
    RX2_PIN, // Serial two receive pin
    RX1_LEVEL, // Serial one voted level
    RX2_LEVEL, // Serial two voted level
    BIT1_TICK, // Serial one bit clock pulse
    BIT2_TICK // Serial two bit clock pulse
);
    input wire logic SYS_CLK;
    input wire logic NRST;
    input wire logic CE;
    input wire logic HSEL;
    input wire logic [31:0] HADDR;
    input wire logic [1:0] HTRANS;
    input wire logic HWRITE;
    input wire logic [2:0] HSIZE;
    input wire logic [31:0] HWDATA;
    input wire logic HREADY;
    output logic [31:0] HRDATA;
    output logic HREADYOUT;
    output logic HRESP;
    input wire logic RX1_PIN;
    input wire logic RX2_PIN;
    output logic RX1_LEVEL;
    output logic RX2_LEVEL;
    output logic BIT1_TICK;
    output logic BIT2_TICK;

    // Register storage, one set per instance, plus the shared disable register and bus state
    logic [7:0] txctl_r [2];
    logic [7:0] rxctl_r [2];
    logic [7:0] rate_r [2];
    logic [7:0] divh_r [2];
    logic [7:0] divl_r [2];
    logic [7:0] peripheral_module_disable_0_r;
    logic [7:0] addr_r;
    logic wr_pend_r;
    logic [1:0] div_wr_r;
    logic [31:0] rdata_nxt;

    // Effective divisor: wide select decides whether the high byte counts
    function automatic logic [15:0] eff_div(input logic [7:0] rate, input logic [7:0] hi,
                                            input logic [7:0] lo);
        return rate[SBR_WIDE_BIT] ? {hi, lo} : {8'h00, lo};
    endfunction

    // Prescale choice from sync, wide and high-speed selects
    function automatic logic [5:0] pre_sel(input logic [7:0] tx, input logic [7:0] rate);
        logic hs;
        logic wd;
        hs = tx[SBR_HSPD_BIT];
        wd = rate[SBR_WIDE_BIT];
        if (tx[SBR_SYNC_BIT]) begin
            return SBR_PRE4_TC;
        end else if (hs && wd) begin
            return SBR_PRE4_TC;
        end else if (hs || wd) begin
            return SBR_PRE16_TC;
        end
        return SBR_PRE64_TC;
    endfunction

    // Address phase decode
    wire addr_phase = HSEL && HREADY && HTRANS[1];
    wire wr_phase = addr_phase && HWRITE;
    wire [7:0] a_lo = HADDR[7:0];

    // Data-phase write decode against the latched address
    wire w_tx1 = wr_pend_r && (addr_r == SBR_S1_TXCTL_OFS);
    wire w_rx1 = wr_pend_r && (addr_r == SBR_S1_RXCTL_OFS);
    wire w_rt1 = wr_pend_r && (addr_r == SBR_S1_RATE_OFS);
    wire w_dh1 = wr_pend_r && (addr_r == SBR_S1_DIVH_OFS);
    wire w_dl1 = wr_pend_r && (addr_r == SBR_S1_DIVL_OFS);
    wire w_tx2 = wr_pend_r && (addr_r == SBR_S2_TXCTL_OFS);
    wire w_rx2 = wr_pend_r && (addr_r == SBR_S2_RXCTL_OFS);
    wire w_rt2 = wr_pend_r && (addr_r == SBR_S2_RATE_OFS);
    wire w_dh2 = wr_pend_r && (addr_r == SBR_S2_DIVH_OFS);
    wire w_dl2 = wr_pend_r && (addr_r == SBR_S2_DIVL_OFS);
    wire w_pmd = wr_pend_r && (addr_r == SBR_PERIPHERAL_MODULE_DISABLE_0_OFS);
    wire [7:0] wbyte = HWDATA[7:0];
    wire [7:0] rate_wmask = ~(8'h01 << SBR_RATE_UNIMP_BIT);

    // Run enables: port enable set and module not disabled
    wire run1 = rxctl_r[0][SBR_SPEN_BIT] && !peripheral_module_disable_0_r[SBR_S1_MD_BIT];
    wire run2 = rxctl_r[1][SBR_SPEN_BIT] && !peripheral_module_disable_0_r[SBR_S2_MD_BIT];
    wire [15:0] div1 = eff_div(rate_r[0], divh_r[0], divl_r[0]);
    wire [15:0] div2 = eff_div(rate_r[1], divh_r[1], divl_r[1]);
    wire [5:0] pre1 = pre_sel(txctl_r[0], rate_r[0]);
    wire [5:0] pre2 = pre_sel(txctl_r[1], rate_r[1]);
    wire tt1;
    wire tt2;
    wire bt1;
    wire bt2;
    wire lv1;
    wire lv2;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (a_lo)
            SBR_S1_TXCTL_OFS: rdata_nxt[7:0] = txctl_r[0];
            SBR_S1_RXCTL_OFS: rdata_nxt[7:0] = rxctl_r[0];
            SBR_S1_RATE_OFS: rdata_nxt[7:0] = rate_r[0];
            SBR_S1_DIVH_OFS: rdata_nxt[7:0] = divh_r[0];
            SBR_S1_DIVL_OFS: rdata_nxt[7:0] = divl_r[0];
            SBR_S2_TXCTL_OFS: rdata_nxt[7:0] = txctl_r[1];
            SBR_S2_RXCTL_OFS: rdata_nxt[7:0] = rxctl_r[1];
            SBR_S2_RATE_OFS: rdata_nxt[7:0] = rate_r[1];
            SBR_S2_DIVH_OFS: rdata_nxt[7:0] = divh_r[1];
            SBR_S2_DIVL_OFS: rdata_nxt[7:0] = divl_r[1];
            SBR_PERIPHERAL_MODULE_DISABLE_0_OFS: rdata_nxt[7:0] = peripheral_module_disable_0_r;
            SBR_STATUS_OFS: rdata_nxt[3:0] = {run2, run1, RX2_LEVEL, RX1_LEVEL};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Bus slave: zero wait state, read data registered in address phase
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            addr_r <= 8'h00;
            wr_pend_r <= 1'b0;
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else if (CE) begin
            wr_pend_r <= wr_phase;
            if (addr_phase) begin
                addr_r <= a_lo;
                HRDATA <= HWRITE ? 32'h0000_0000 : rdata_nxt;
            end
        end
    end

    // Instance one register writes, each set kept separately
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            txctl_r[0] <= SBR_REG_RST;
            rxctl_r[0] <= SBR_REG_RST;
            rate_r[0] <= SBR_REG_RST;
            divh_r[0] <= SBR_REG_RST;
            divl_r[0] <= SBR_REG_RST;
        end else if (CE) begin
            if (w_tx1) txctl_r[0] <= wbyte;
            if (w_rx1) rxctl_r[0] <= wbyte;
            if (w_rt1) rate_r[0] <= wbyte & rate_wmask;
            if (w_dh1) divh_r[0] <= wbyte;
            if (w_dl1) divl_r[0] <= wbyte;
        end
    end

    // Instance two register writes
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            txctl_r[1] <= SBR_REG_RST;
            rxctl_r[1] <= SBR_REG_RST;
            rate_r[1] <= SBR_REG_RST;
            divh_r[1] <= SBR_REG_RST;
            divl_r[1] <= SBR_REG_RST;
        end else if (CE) begin
            if (w_tx2) txctl_r[1] <= wbyte;
            if (w_rx2) rxctl_r[1] <= wbyte;
            if (w_rt2) rate_r[1] <= wbyte & rate_wmask;
            if (w_dh2) divh_r[1] <= wbyte;
            if (w_dl2) divl_r[1] <= wbyte;
        end
    end

    // Disable register and divisor-write restart flags; restart lands after the new value
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            peripheral_module_disable_0_r <= SBR_REG_RST;
            div_wr_r <= 2'h0;
        end else if (CE) begin
            if (w_pmd) peripheral_module_disable_0_r <= wbyte;
            div_wr_r <= {w_dh2 || w_dl2, w_dh1 || w_dl1};
        end
    end

    // Rate timers, one per instance
    sbr_timer u_tmr1 (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .ce(CE),
        .run(run1),
        .restart(div_wr_r[0]),
        .divisor(div1),
        .pre_tc(pre1),
        .timer_tick(tt1),
        .bit_tick(bt1)
    );
    sbr_timer u_tmr2 (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .ce(CE),
        .run(run2),
        .restart(div_wr_r[1]),
        .divisor(div2),
        .pre_tc(pre2),
        .timer_tick(tt2),
        .bit_tick(bt2)
    );

    // Samplers take one sample per timer tick and vote over the last three, with no alignment
    // to the bit centre; async runs at 16x and 64x, and at 4x with wide and high-speed both set
    sbr_vote u_vote1 (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .ce(CE),
        .sample(tt1),
        .pin(RX1_PIN),
        .level(lv1)
    );
    sbr_vote u_vote2 (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .ce(CE),
        .sample(tt2),
        .pin(RX2_PIN),
        .level(lv2)
    );

    // Output flops
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            RX1_LEVEL <= 1'b1;
            RX2_LEVEL <= 1'b1;
            BIT1_TICK <= 1'b0;
            BIT2_TICK <= 1'b0;
        end else if (CE) begin
            RX1_LEVEL <= lv1;
            RX2_LEVEL <= lv2;
            BIT1_TICK <= bt1;
            BIT2_TICK <= bt2;
        end
    end
endmodule

// ==== dv/sbr_assertions.sv ====
// Checker of bus answers and tick pulses at the rate generator ports
`timescale 1ns/100ps
module sbr_assertions
    import sbr_pkg::*;
(
    input wire logic SYS_CLK, // Clock
    input wire logic NRST, // Reset, active low
    input wire logic CE, // Clock enable
    input wire logic HSEL, // Select
    input wire logic [31:0] HADDR, // Address
    input wire logic [1:0] HTRANS, // Transfer type
    input wire logic HWRITE, // Write
    input wire logic HREADY, // Bus ready
    input wire logic [31:0] HRDATA, // Read data
    input wire logic HREADYOUT, // Slave ready
    input wire logic HRESP, // Response
    input wire logic RX1_LEVEL, // Voted level one
    input wire logic RX2_LEVEL, // Voted level two
    input wire logic BIT1_TICK, // Bit pulse one
    input wire logic BIT2_TICK // Bit pulse two
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // Read address phase taken this edge
    wire rd_go = HSEL && HREADY && HTRANS[1] && !HWRITE && CE;
    ready_high_a: assert property (HREADYOUT) else $error("slave inserted a wait");
    resp_okay_a: assert property (!HRESP) else $error("error response");
    upper_zero_a: assert property (HRDATA[31:8] == 24'h000000) else $error("upper bits set");
    rate_gap_a: assert property (rd_go && (HADDR[7:0] == SBR_S1_RATE_OFS ||
        HADDR[7:0] == SBR_S2_RATE_OFS) |=> !HRDATA[SBR_RATE_UNIMP_BIT])
        else $error("rate control bit 2 read as one");
    unmapped_zero_a: assert property (rd_go && HADDR[7:0] == 8'h50 |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    tick1_gap_a: assert property (BIT1_TICK |=> !BIT1_TICK [*3])
        else $error("serial one ticks too close");
    tick2_gap_a: assert property (BIT2_TICK |=> !BIT2_TICK [*3])
        else $error("serial two ticks too close");
    reset_idle_a: assert property ($rose(NRST) |-> RX1_LEVEL && RX2_LEVEL &&
        !BIT1_TICK && !BIT2_TICK) else $error("outputs not idle after reset");
endmodule

// ==== dv/sbr_partner.sv ====
// Remote serial transmitter model driving both receive lines
`timescale 1ns/100ps
module sbr_partner (
    input wire logic clk, // System clock
    output logic rx1, // Serial one line
    output logic rx2 // Serial two line
);
    // Lines idle at mark level
    initial begin
        rx1 = 1'b1;
        rx2 = 1'b1;
    end
    // Drive both lines just after a rising edge
    task automatic hold(input logic v);
        @(posedge clk);
        rx1 <= v;
        rx2 <= v;
    endtask
    // Low glitch of len cycles, then back to mark
    task automatic pulse(input int len);
        hold(1'b0);
        repeat (len) @(posedge clk);
        rx1 <= 1'b1;
        rx2 <= 1'b1;
    endtask
endmodule

// ==== dv/sbr_top_tb.sv ====
// Self-checking bench for the dual rate generator
`timescale 1ns/100ps
module sbr_top_tb;
    import sbr_pkg::*;
    logic SYS_CLK = 1'b0;
    logic NRST = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, q;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0, CE = 1'b1, HSEL = 1'b1;
    wire [31:0] HRDATA;
    wire HREADYOUT, HRESP, RX1_PIN, RX2_PIN, RX1_LEVEL, RX2_LEVEL, BIT1_TICK, BIT2_TICK;
    wire [2:0] sig = {BIT2_TICK, BIT1_TICK, HREADYOUT};
    int errors = 0, num_checks = 0, c, k1, k2;
    logic [7:0] ofs [11] = '{SBR_S1_TXCTL_OFS, SBR_S1_RXCTL_OFS, SBR_S1_RATE_OFS,
        SBR_S1_DIVH_OFS, SBR_S1_DIVL_OFS, SBR_S2_TXCTL_OFS, SBR_S2_RXCTL_OFS,
        SBR_S2_RATE_OFS, SBR_S2_DIVH_OFS, SBR_S2_DIVL_OFS, SBR_PERIPHERAL_MODULE_DISABLE_0_OFS};
    logic [7:0] ctx [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h10, 8'h14};
    logic [7:0] crt [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
    int cex [6] = '{192, 48, 4144, 1036, 12, 1036};
    // Single slave, so its ready is the bus ready
    sbr_top dut_u (.SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .RX1_PIN(RX1_PIN), .RX2_PIN(RX2_PIN), .RX1_LEVEL(RX1_LEVEL),
        .RX2_LEVEL(RX2_LEVEL), .BIT1_TICK(BIT1_TICK), .BIT2_TICK(BIT2_TICK));
    sbr_partner part_u (.clk(SYS_CLK), .rx1(RX1_PIN), .rx2(RX2_PIN));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for ready (0) or a bit tick (1, 2); n is cycles taken
    task automatic wait_on(input int s, output int n);
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (sig[s] !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            errors++;
            give_verdict();
        end
    endtask
    // One single transfer: address phase, then data phase
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge SYS_CLK);
        HADDR <= {24'h000000, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        wait_on(0, n);
        HTRANS <= 2'h0;
        HWDATA <= {24'h000000, d};
        wait_on(0, n);
        q = HRDATA;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        chk(q, {24'h000000, e});
    endtask
    // Interval between the second and third ticks after a reconfiguration;
    // the first tick may still reload the counter with the old divisor
    task automatic period(input int s, input int e);
        int n;
        wait_on(s, n);
        wait_on(s, n);
        wait_on(s, n);
        chk(n, e);
    endtask
    // Count ticks of both ports over a settled window
    task automatic cnt(output int t1, output int t2);
        t1 = 0;
        t2 = 0;
        repeat (40) @(posedge SYS_CLK);
        repeat (240) begin
            @(posedge SYS_CLK);
            t1 += int'(BIT1_TICK === 1'b1);
            t2 += int'(BIT2_TICK === 1'b1);
        end
    endtask
    initial begin
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        repeat (16) @(posedge SYS_CLK);
        NRST <= 1'b1;
        foreach (ofs[i]) rdc(ofs[i], 8'h00);
        rdc(SBR_STATUS_OFS, 8'h03);
        $display("reset values done");
        // Distinct pattern in every register shows each is its own
        foreach (ofs[i]) xfer(ofs[i], 1'b1, 8'(i * 16 + 4));
        foreach (ofs[i]) rdc(ofs[i], 8'((i == 2 || i == 7) ? i * 16 : i * 16 + 4));
        xfer(8'h50, 1'b1, 8'hAA);
        rdc(8'h50, 8'h00);
        // Deselected transfer must leave the register alone
        HSEL <= 1'b0;
        xfer(SBR_S1_DIVL_OFS, 1'b1, 8'hFF);
        HSEL <= 1'b1;
        rdc(SBR_S1_DIVL_OFS, 8'h44);
        $display("register access done");
        // High byte 01 must be ignored until the wide select is set
        xfer(SBR_S1_DIVH_OFS, 1'b1, 8'h01);
        xfer(SBR_S1_DIVL_OFS, 1'b1, 8'h02);
        xfer(SBR_S1_RXCTL_OFS, 1'b1, 8'h80);
        xfer(SBR_PERIPHERAL_MODULE_DISABLE_0_OFS, 1'b1, 8'h00);
        for (int k = 0; k < 6; k++) begin
            xfer(SBR_S1_TXCTL_OFS, 1'b1, ctx[k]);
            xfer(SBR_S1_RATE_OFS, 1'b1, crt[k]);
            period(1, cex[k]);
        end
        $display("rate formulas done");
        xfer(SBR_S2_TXCTL_OFS, 1'b1, 8'h10);
        xfer(SBR_S2_RATE_OFS, 1'b1, 8'h00);
        xfer(SBR_S2_DIVL_OFS, 1'b1, 8'h04);
        xfer(SBR_S2_RXCTL_OFS, 1'b1, 8'h80);
        period(2, 20);
        // Restart: a high byte write mid-period must not wait out the old count
        wait_on(1, c);
        repeat (100) @(posedge SYS_CLK);
        xfer(SBR_S1_DIVH_OFS, 1'b1, 8'h00);
        wait_on(1, c);
        chk(c <= 30, 1);
        period(1, 12);
        $display("restart done");
        xfer(SBR_PERIPHERAL_MODULE_DISABLE_0_OFS, 1'b1, 8'h02);
        cnt(k1, k2);
        chk(k1, 0);
        chk(k2, 12);
        xfer(SBR_PERIPHERAL_MODULE_DISABLE_0_OFS, 1'b1, 8'h04);
        cnt(k1, k2);
        chk(k1, 20);
        chk(k2, 0);
        $display("module disable done");
        // Clock enable low just after a tick freezes the timer with its pulse low
        wait_on(1, c);
        CE <= 1'b0;
        cnt(k1, k2);
        chk(k1, 0);
        chk(k2, 0);
        CE <= 1'b1;
        period(1, 12);
        $display("clock enable done");
        xfer(SBR_PERIPHERAL_MODULE_DISABLE_0_OFS, 1'b1, 8'h00);
        // A one-cycle glitch hits at most one of three samples
        part_u.pulse(1);
        k1 = 1;
        repeat (30) begin
            @(posedge SYS_CLK);
            k1 = k1 & int'(RX1_LEVEL === 1'b1 && RX2_LEVEL === 1'b1);
        end
        chk(k1, 1);
        part_u.hold(1'b0);
        repeat (60) @(posedge SYS_CLK);
        chk({RX1_LEVEL, RX2_LEVEL}, 2'b00);
        rdc(SBR_STATUS_OFS, 8'h0C);
        part_u.hold(1'b1);
        $display("sampling done");
        // Reset in mid-run returns every register and output to idle
        NRST <= 1'b0;
        repeat (16) @(posedge SYS_CLK);
        NRST <= 1'b1;
        foreach (ofs[i]) rdc(ofs[i], 8'h00);
        rdc(SBR_STATUS_OFS, 8'h03);
        $display("second reset done");
        give_verdict();
    end
endmodule
bind sbr_top sbr_assertions chk_u (.SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX1_LEVEL(RX1_LEVEL), .RX2_LEVEL(RX2_LEVEL),
    .BIT1_TICK(BIT1_TICK), .BIT2_TICK(BIT2_TICK));
